// >>> testbench/tb.sv
// Self-checking bench for the two-wire thermometer and memory slave
`timescale 1ns/1ps
module tb;
    import tsense_pkg::*;
    localparam int WR_N = 400;
    logic        clk, rst_b, scl, sda_m, sda_w, sda_out, sda_oe, a;
    logic        cont_mode, conv_start, conv_stop, write_busy;
    logic [2:0]  sel_r;
    logic [15:0] temp_r;
    logic [7:0]  cfg_value, seed, q, v;
    logic [7:0]  mem [256];
    bit          known [256];
    int          miscompares, samples_checked, n_start, n_stop;

    assign sda_w = sda_m & ~(sda_oe & ~sda_out);
    temp_eeprom_slave #(.WR_CNT(WR_N)) temp_eeprom_slave_i (
        .clk(clk), .rst_b(rst_b), .scl_pin(scl), .sda_pin(sda_w), .sda_out(sda_out),
        .sda_oe(sda_oe), .addr_select_0(sel_r[0]), .addr_select_1(sel_r[1]),
        .addr_select_2(sel_r[2]), .temp_value(temp_r), .cfg_value(cfg_value),
        .cont_mode(cont_mode), .conv_start(conv_start), .conv_stop(conv_stop),
        .write_busy(write_busy));
    two_wire_master two_wire_master_i (.clk(clk), .sda_w(sda_w), .scl(scl), .sda_m(sda_m));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(negedge clk) begin
        if (conv_start === 1'b1) n_start++;
        if (conv_stop === 1'b1) n_stop++;
    end
    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [7:0] slot(input logic [7:0] b, input int i);
        return {b[7:3], b[2:0] + 3'(i)};
    endfunction : slot
    task automatic nxt();
        seed = lfsr(seed);
        v = seed;
    endtask : nxt
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wb(input logic [7:0] d, input logic ok);
        two_wire_master_i.xfer(d, 1'b1, q, a);
        chk(!a, ok);
    endtask : wb
    task automatic hdr(input logic [7:0] cmd, input logic ok);
        two_wire_master_i.start_cond();
        wb({DEV_CODE_DEF, sel_r, 1'b0}, 1'b1);
        wb(cmd, ok);
    endtask : hdr
    task automatic rd_start();
        two_wire_master_i.start_cond();
        wb({DEV_CODE_DEF, sel_r, 1'b1}, 1'b1);
    endtask : rd_start
    task automatic poll();
        int n;
        n = 0;
        chk(write_busy, 1'b1);
        do begin
            n++;
            two_wire_master_i.start_cond();
            two_wire_master_i.xfer({DEV_CODE_DEF, sel_r, 1'b0}, 1'b1, q, a);
            two_wire_master_i.xfer(CMD_MEM, 1'b1, q, a);
            two_wire_master_i.stop_cond();
            if (n == 1) chk(a, 1'b1);
        end while (a !== 1'b0 && n < 8);
        chk(a, 1'b0);
        chk(write_busy, 1'b0);
    endtask : poll
    task automatic mw(input logic [7:0] base, input int n, input bit pat, input bit abort);
        hdr(CMD_MEM, 1'b1);
        wb(base, 1'b1);
        for (int i = 0; i < n; i++) begin
            nxt();
            if (pat) v = 8'(i * 17);
            wb(v, 1'b1);
            if (!abort) begin
                mem[slot(base, i)] = v;
                known[slot(base, i)] = 1'b1;
            end
        end
        if (abort) two_wire_master_i.start_cond();
        two_wire_master_i.stop_cond();
        if (abort) chk(write_busy, 1'b0);
        else poll();
    endtask : mw
    task automatic mr(input logic [7:0] base, input int n);
        logic [7:0] p;
        hdr(CMD_MEM, 1'b1);
        wb(base, 1'b1);
        rd_start();
        for (int i = 0; i < n; i++) begin
            p = base + 8'(i);
            two_wire_master_i.xfer(8'hff, i == n - 1, q, a);
            if (known[p]) chk(q, mem[p]);
        end
        two_wire_master_i.stop_cond();
    endtask : mr
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
    initial begin
        rst_b = 1'b0;
        sel_r = 3'h0;
        temp_r = 16'h0000;
        seed = 8'h45;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        nxt();
        sel_r <= v[2:0];
        nxt();
        temp_r[15:8] <= v;
        nxt();
        temp_r[7:0] <= v;
        repeat (4) @(posedge clk);
        two_wire_master_i.start_cond();
        wb({DEV_CODE_DEF, ~sel_r, 1'b0}, 1'b0);
        two_wire_master_i.stop_cond();
        for (int k = 0; k < 2; k++) begin
            nxt();
            v = (k == 1) ? CFG_CONT : (v | 8'h01);
            hdr(CMD_CFG, 1'b1);
            wb(v, 1'b1);
            two_wire_master_i.stop_cond();
            poll();
            chk(cfg_value, v);
            chk(cont_mode, k == 1);
            hdr(CMD_CFG, 1'b1);
            rd_start();
            two_wire_master_i.xfer(8'hff, 1'b1, q, a);
            chk(q, v);
            two_wire_master_i.stop_cond();
        end
        hdr(CMD_CONV, 1'b1);
        two_wire_master_i.stop_cond();
        chk(16'(n_start), 16'h0001);
        hdr(CMD_HALT, 1'b1);
        two_wire_master_i.stop_cond();
        chk(16'(n_stop), 16'h0001);
        hdr(CMD_TEMP, 1'b1);
        rd_start();
        two_wire_master_i.xfer(8'hff, 1'b0, q, a);
        chk(q, temp_r[15:8]);
        two_wire_master_i.xfer(8'hff, 1'b1, q, a);
        chk(q, temp_r[7:0]);
        two_wire_master_i.stop_cond();
        mw(8'h00, 10, 1'b1, 1'b0);
        mw(8'hfd, 8, 1'b0, 1'b0);
        mw(8'h02, 3, 1'b0, 1'b1);
        mr(8'hf8, 16);
        print_verdict();
    end
endmodule : tb

// >>> testbench/two_wire_master.sv
// Bus master model that drives the two-wire pins of the slave
`timescale 1ns/1ps
module two_wire_master (
    input  wire logic clk,
    input  wire logic sda_w,
    output logic      scl,
    output logic      sda_m
);
    localparam int HALF = 8;
    initial begin
        scl   = 1'b1;
        sda_m = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // Data moves only while the clock is low; sampled mid-high
    task automatic bit_io(input logic d, output logic s);
        tick(1);
        sda_m <= d;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF / 2);
        @(negedge clk) s = sda_w;
        tick(HALF / 2);
        scl <= 1'b0;
    endtask : bit_io
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic s);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], b);
            q[i] = b;
        end
        bit_io(m, s);
    endtask : xfer
    task automatic start_cond();
        tick(1);
        sda_m <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_m <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        tick(1);
        sda_m <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_m <= 1'b1;
        tick(HALF);
    endtask : stop_cond
endmodule : two_wire_master

// >>> verilog/nv_if.sv
// Link between the command engine and the nonvolatile store
`timescale 1ns/1ps
interface nv_if;
    logic       buf_we;
    logic [2:0] buf_idx;
    logic [7:0] buf_data;
    logic       commit;
    logic       abort;
    logic [4:0] base;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic       busy;

    modport engine (
        output buf_we, buf_idx, buf_data, commit, abort, base, rd_addr,
        input  rd_data, busy
    );
    modport store (
        input  buf_we, buf_idx, buf_data, commit, abort, base, rd_addr,
        output rd_data, busy
    );
endinterface : nv_if

// >>> verilog/nv_store.sv
// Page buffer, memory array and programming timer
`timescale 1ns/1ps
module nv_store
    import tsense_pkg::*;
#(
    parameter int WR_CNT = WR_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst_b,
    nv_if.store       nv
);
    localparam int CW = $clog2(WR_CNT + 1);

    logic [7:0]            mem    [MEM_BYTES];
    logic [7:0]            page_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_r;
    logic [PAGE_BYTES-1:0] mask_nxt;
    logic [CW-1:0]         cnt_r;
    logic [CW-1:0]         cnt_nxt;
    logic                  busy_r;
    logic                  busy_nxt;
    logic                  go;

    assign go         = nv.commit && !busy_r;
    assign nv.busy    = busy_r;
    assign nv.rd_data = mem[nv.rd_addr];

    always_comb begin
        mask_nxt = mask_r;
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        if (busy_r) begin
            cnt_nxt = cnt_r - CW'(1);
            if (cnt_r == CW'(1)) begin
                busy_nxt = 1'b0;
            end
        end
        if (nv.abort || go) begin
            mask_nxt = '0;
        end
        if (nv.buf_we) begin
            mask_nxt[nv.buf_idx] = 1'b1;
        end
        if (go) begin
            busy_nxt = 1'b1;
            cnt_nxt  = CW'(WR_CNT);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_r <= '0;
            cnt_r  <= '0;
            busy_r <= 1'b0;
        end else begin
            mask_r <= mask_nxt;
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Only bytes actually received are programmed; the rest keep old data
    always_ff @(posedge clk) begin
        if (nv.buf_we) begin
            page_r[nv.buf_idx] <= nv.buf_data;
        end
        for (int i = 0; i < PAGE_BYTES; i++) begin
            if (go && mask_r[i]) begin
                mem[{nv.base, 3'(i)}] <= page_r[i];
            end
        end
    end

    a_prog_time: assert property (
        @(posedge clk) disable iff (!rst_b)
        go |=> busy_r && cnt_r == CW'(WR_CNT)
    ) else $error("programming timer not loaded");
endmodule : nv_store

// >>> verilog/temp_eeprom_slave.sv
// Command layer of the two-wire thermometer and memory slave
`timescale 1ns/1ps
module temp_eeprom_slave
    import tsense_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = DEV_CODE_DEF,
    parameter int         WR_CNT   = WR_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        scl_pin,
    input  wire logic        sda_pin,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic        addr_select_0,
    input  wire logic        addr_select_1,
    input  wire logic        addr_select_2,
    input  wire logic [15:0] temp_value,
    output logic [7:0]       cfg_value,
    output logic             cont_mode,
    output logic             conv_start,
    output logic             conv_stop,
    output logic             write_busy
);
    ////////////////////////////////////////////////////////////////////////////
    nv_if nv ();

    nv_store #(
        .WR_CNT (WR_CNT)
    ) u_store (
        .clk   (clk),
        .rst_b (rst_b),
        .nv    (nv.store)
    );

    function automatic logic cmd_known(input logic [7:0] c);
        return c == CMD_MEM || c == CMD_CFG || c == CMD_TEMP ||
               c == CMD_CONV || c == CMD_HALT;
    endfunction : cmd_known

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage three only feeds edge detection
    logic       scl_s1_r;
    logic       scl_s2_r;
    logic       scl_s3_r;
    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       sda_s3_r;
    logic [2:0] sel_s1_r;
    logic [2:0] sel_s2_r;
    logic       sda_lo_r;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_s3_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_s3_r <= 1'b1;
            sel_s1_r <= 3'h0;
            sel_s2_r <= 3'h0;
            sda_lo_r <= 1'b0;
        end else begin
            scl_s1_r <= scl_pin;
            scl_s2_r <= scl_s1_r;
            scl_s3_r <= scl_s2_r;
            sda_s1_r <= sda_pin;
            sda_s2_r <= sda_s1_r;
            sda_s3_r <= sda_s2_r;
            sel_s1_r <= {addr_select_2, addr_select_1, addr_select_0};
            sel_s2_r <= sel_s1_r;
            sda_lo_r <= 1'b0;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl_rise = scl_s2_r && !scl_s3_r;
    assign scl_fall = !scl_s2_r && scl_s3_r;
    assign start_c  = scl_s2_r && scl_s3_r && sda_s3_r && !sda_s2_r;
    assign stop_c   = scl_s2_r && scl_s3_r && !sda_s3_r && sda_s2_r;

    ////////////////////////////////////////////////////////////////////////////
    // Byte engine and command interpreter
    bus_st_t    st_r,     st_nxt;
    phase_t     ph_r,     ph_nxt;
    logic [3:0] bit_r,    bit_nxt;
    logic [7:0] sh_r,     sh_nxt;
    logic [7:0] cmd_r,    cmd_nxt;
    logic [7:0] ptr_r,    ptr_nxt;
    logic [7:0] cfgp_r,   cfgp_nxt;
    logic [7:0] cfg_r,    cfg_nxt;
    logic [7:0] tlo_r,    tlo_nxt;
    logic       rw_r,     rw_nxt;
    logic       tsel_r,   tsel_nxt;
    logic       mack_r,   mack_nxt;
    logic       oe_r,     oe_nxt;
    logic       wpend_r,  wpend_nxt;
    logic       cpend_r,  cpend_nxt;
    logic       cont_r,   cont_nxt;
    logic       cstart_r, cstart_nxt;
    logic       cstop_r,  cstop_nxt;
    logic       addr_hit;
    logic       ack_c;
    logic       load_c;
    logic [7:0] tx_byte;
    logic [7:0] wr_step;
    logic [7:0] rd_step;

    assign addr_hit = sh_r[7:4] == DEV_CODE && sh_r[3:1] == sel_s2_r;
    assign wr_step  = {ptr_r[7:3], ptr_r[2:0] + 3'h1};
    assign rd_step  = ptr_r + 8'h01;

    assign nv.buf_idx  = ptr_r[2:0];
    assign nv.buf_data = sh_r;
    assign nv.base     = ptr_r[7:3];
    assign nv.rd_addr  = ptr_r;

    always_comb begin
        unique case (cmd_r)
            CMD_MEM:  tx_byte = nv.rd_data;
            CMD_TEMP: tx_byte = tsel_r ? tlo_r : temp_value[15:8];
            CMD_CFG:  tx_byte = cfg_r;
            default:  tx_byte = IDLE_BYTE;
        endcase
    end

    always_comb begin
        st_nxt     = st_r;
        ph_nxt     = ph_r;
        bit_nxt    = bit_r;
        sh_nxt     = sh_r;
        cmd_nxt    = cmd_r;
        ptr_nxt    = ptr_r;
        cfgp_nxt   = cfgp_r;
        cfg_nxt    = cfg_r;
        tlo_nxt    = tlo_r;
        rw_nxt     = rw_r;
        tsel_nxt   = tsel_r;
        mack_nxt   = mack_r;
        oe_nxt     = oe_r;
        wpend_nxt  = wpend_r;
        cpend_nxt  = cpend_r;
        cont_nxt   = cfg_r == CFG_CONT;
        cstart_nxt = 1'b0;
        cstop_nxt  = 1'b0;
        nv.buf_we  = 1'b0;
        nv.commit  = 1'b0;
        nv.abort   = 1'b0;
        ack_c      = 1'b0;
        load_c     = 1'b0;
        if (start_c) begin
            st_nxt    = ST_ADDR;
            bit_nxt   = 4'h0;
            oe_nxt    = 1'b0;
            nv.abort  = wpend_r || cpend_r;
            wpend_nxt = 1'b0;
            cpend_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt    = ST_IDLE;
            oe_nxt    = 1'b0;
            nv.commit = wpend_r || cpend_r;
            if (cpend_r) begin
                cfg_nxt = cfgp_r;
            end
            wpend_nxt = 1'b0;
            cpend_nxt = 1'b0;
        end else begin
            unique case (st_r)
                ST_IDLE: begin
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise) begin
                        sh_nxt  = {sh_r[6:0], sda_s2_r};
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall && bit_r == BYTE_BITS) begin
                        if (st_r == ST_ADDR) begin
                            ack_c  = addr_hit;
                            rw_nxt = sh_r[0];
                            if (addr_hit && !sh_r[0]) begin
                                ph_nxt = PH_CMD;
                            end
                        end else begin
                            unique case (ph_r)
                                PH_CMD: begin
                                    if (!nv.busy && cmd_known(sh_r)) begin
                                        ack_c      = 1'b1;
                                        cmd_nxt    = sh_r;
                                        tsel_nxt   = 1'b0;
                                        cstart_nxt = sh_r == CMD_CONV;
                                        cstop_nxt  = sh_r == CMD_HALT;
                                        ph_nxt     = (sh_r == CMD_MEM || sh_r == CMD_CFG) ?
                                                     PH_PARAM : PH_DATA;
                                    end
                                end
                                PH_PARAM: begin
                                    ack_c  = 1'b1;
                                    ph_nxt = PH_DATA;
                                    if (cmd_r == CMD_MEM) begin
                                        ptr_nxt = sh_r;
                                    end else begin
                                        cfgp_nxt  = sh_r;
                                        cpend_nxt = 1'b1;
                                    end
                                end
                                PH_DATA: begin
                                    if (cmd_r == CMD_MEM) begin
                                        ack_c     = 1'b1;
                                        nv.buf_we = 1'b1;
                                        wpend_nxt = 1'b1;
                                        ptr_nxt   = wr_step;
                                    end
                                end
                                default: begin
                                end
                            endcase
                        end
                        oe_nxt = ack_c;
                        st_nxt = ack_c ? ST_ACK : ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        bit_nxt = 4'h0;
                        oe_nxt  = 1'b0;
                        load_c  = rw_r;
                        st_nxt  = rw_r ? ST_TX : ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        bit_nxt = bit_r + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_r == BYTE_BITS) begin
                            oe_nxt = 1'b0;
                            st_nxt = ST_MACK;
                        end else begin
                            sh_nxt = {sh_r[6:0], 1'b0};
                            oe_nxt = !sh_r[6];
                        end
                    end
                end
                ST_MACK: begin
                    if (scl_rise) begin
                        mack_nxt = !sda_s2_r;
                    end else if (scl_fall) begin
                        bit_nxt = 4'h0;
                        load_c  = mack_r;
                        st_nxt  = mack_r ? ST_TX : ST_IDLE;
                    end
                end
                default: st_nxt = ST_IDLE;
            endcase
        end
        if (load_c) begin
            sh_nxt   = tx_byte;
            oe_nxt   = !tx_byte[7];
            tsel_nxt = 1'b1;
            if (!tsel_r) begin
                tlo_nxt = temp_value[7:0];
            end
            if (cmd_r == CMD_MEM) begin
                ptr_nxt = rd_step;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r     <= ST_IDLE;
            ph_r     <= PH_CMD;
            bit_r    <= 4'h0;
            sh_r     <= 8'h00;
            cmd_r    <= 8'h00;
            ptr_r    <= 8'h00;
            cfgp_r   <= 8'h00;
            cfg_r    <= CFG_RST;
            tlo_r    <= 8'h00;
            rw_r     <= 1'b0;
            tsel_r   <= 1'b0;
            mack_r   <= 1'b0;
            oe_r     <= 1'b0;
            wpend_r  <= 1'b0;
            cpend_r  <= 1'b0;
            cont_r   <= 1'b0;
            cstart_r <= 1'b0;
            cstop_r  <= 1'b0;
        end else begin
            st_r     <= st_nxt;
            ph_r     <= ph_nxt;
            bit_r    <= bit_nxt;
            sh_r     <= sh_nxt;
            cmd_r    <= cmd_nxt;
            ptr_r    <= ptr_nxt;
            cfgp_r   <= cfgp_nxt;
            cfg_r    <= cfg_nxt;
            tlo_r    <= tlo_nxt;
            rw_r     <= rw_nxt;
            tsel_r   <= tsel_nxt;
            mack_r   <= mack_nxt;
            oe_r     <= oe_nxt;
            wpend_r  <= wpend_nxt;
            cpend_r  <= cpend_nxt;
            cont_r   <= cont_nxt;
            cstart_r <= cstart_nxt;
            cstop_r  <= cstop_nxt;
        end
    end

    assign sda_out    = sda_lo_r;
    assign sda_oe     = oe_r;
    assign cfg_value  = cfg_r;
    assign cont_mode  = cont_r;
    assign conv_start = cstart_r;
    assign conv_stop  = cstop_r;
    assign write_busy = nv.busy;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_byte_end;
        scl_fall && bit_r == BYTE_BITS;
    endsequence

    sequence s_cmd_end(logic [7:0] c);
        st_r == ST_RX && ph_r == PH_CMD && !nv.busy && sh_r == c ##0 s_byte_end;
    endsequence

    a_addr_ack: assert property (
        st_r == ST_ADDR && addr_hit ##0 s_byte_end |=> oe_r && st_r == ST_ACK
    ) else $error("matching address not acknowledged");

    a_addr_miss: assert property (
        st_r == ST_ADDR && !addr_hit ##0 s_byte_end |=> !oe_r && st_r == ST_IDLE
    ) else $error("foreign address acknowledged");

    a_busy_nack: assert property (
        st_r == ST_RX && ph_r == PH_CMD && nv.busy ##0 s_byte_end |=> !oe_r
    ) else $error("command acknowledged while programming");

    a_conv_pulse: assert property (
        s_cmd_end(CMD_CONV) |=> conv_start && oe_r ##1 !conv_start
    ) else $error("start conversion not pulsed");

    a_halt_pulse: assert property (
        s_cmd_end(CMD_HALT) |=> conv_stop && oe_r ##1 !conv_stop
    ) else $error("stop conversion not pulsed");

    a_cfg_store: assert property (
        stop_c && cpend_r |=> cfg_value == $past(cfgp_r)
    ) else $error("configuration byte not stored");

    a_cont_mode: assert property (
        $changed(cfg_r) |=> cont_mode == ($past(cfg_r) == CFG_CONT)
    ) else $error("continuous mode does not follow configuration");

    a_stop_prog: assert property (
        stop_c && wpend_r |-> nv.commit ##1 write_busy
    ) else $error("stop did not start programming");

    a_start_abort: assert property (
        start_c && wpend_r |-> nv.abort && !nv.commit ##1 !wpend_r
    ) else $error("repeated start did not abandon write");

    a_data_wrap: assert property (
        st_r == ST_RX && ph_r == PH_DATA && cmd_r == CMD_MEM ##0 s_byte_end
        |=> oe_r && ptr_r == $past(wr_step)
    ) else $error("write pointer step wrong");

    a_read_step: assert property (
        load_c && cmd_r == CMD_MEM |=> ptr_r == $past(rd_step)
    ) else $error("read pointer not advanced");

    a_read_wrap: assert property (
        load_c && cmd_r == CMD_MEM && ptr_r == 8'hff |=> ptr_r == 8'h00
    ) else $error("read pointer did not wrap");
endmodule : temp_eeprom_slave

// >>> verilog/tsense_pkg.sv
// Constants and types of the two-wire thermometer and memory slave
package tsense_pkg;
    localparam logic [7:0] CMD_MEM      = 8'h17;
    localparam logic [7:0] CMD_CFG      = 8'hac;
    localparam logic [7:0] CMD_TEMP     = 8'haa;
    localparam logic [7:0] CMD_CONV     = 8'hee;
    localparam logic [7:0] CMD_HALT     = 8'h22;
    localparam logic [7:0] CFG_CONT     = 8'h00;
    localparam logic [7:0] CFG_RST      = 8'h00;
    localparam logic [7:0] IDLE_BYTE    = 8'hff;
    localparam logic [3:0] DEV_CODE_DEF = 4'h5;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam int         MEM_BYTES    = 256;
    localparam int         PAGE_BYTES   = 8;
    localparam int         CLK_HZ       = 50_000_000;
    localparam int         WR_TIME_MS   = 10;
    localparam int         WR_CYCLES    = WR_TIME_MS * (CLK_HZ / 1000);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACK  = 3'b010,
        ST_RX   = 3'b011,
        ST_TX   = 3'b100,
        ST_MACK = 3'b101
    } bus_st_t;

    typedef enum logic [1:0] {
        PH_CMD   = 2'b00,
        PH_PARAM = 2'b01,
        PH_DATA  = 2'b10
    } phase_t;
endpackage : tsense_pkg
